/* File: design/psc_config_decoder.sv */
// Pin-strap configuration decoder: current limit, filter zero, address, image
//
// How it works
// RULE_01 - On the high-current variant each current-limit bin maps to a limit, short 15 A, float 30 A, top 60 A.
// RULE_02 - On the low-current variant a separate map applies, short 15 A, float 25 A, top 25 A.
// RULE_03 - Each current-limit bin also picks a filter-zero index 0..4, default caps 1, 2, 4, 6, 8 pF.
// RULE_04 - The filter-zero setting can be written over the bus at bits 14:12 of register 0x64.
// RULE_05 - Cap codes for index 0 sit in 0x64[14:12] and for indices 1..4 in 0x62 nibbles 0..3.
// RULE_06 - The shared-pin bin becomes the slave-address offset added to the base address.
// RULE_07 - The shared-pin bin k selects stored image k at power-up.
// RULE_08 - The address offset from the shared pin never exceeds 4.
// RULE_09 - Boards must not rely on more than five images or offsets above 4.
// RULE_10 - Images are taken as consecutive from image slot zero, so bin equals position.
// RULE_11 - Strap values apply only while their override bit in 0x5E is 0 (bits 0-1 limit; bit 2 swaps the zero cap, not the index output).
// RULE_12 - With 0x42 bit 6 set the pin offset is dropped but image selection remains.
// RULE_13 - Strap bins are sampled once after reset, before the image load, and held.
`timescale 1ns/1ps
`default_nettype none
module psc_config_decoder
   import psc_pkg::*;
#(
   parameter int SETTLE_CYC = STRAP_SETTLE_CYC
)(
   input  wire logic        sys_clk_in,
   input  wire logic        srst_in,
   input  wire logic [3:0]  ilim_bin_in,
   input  wire logic [3:0]  addr_bin_in,
   input  wire logic        bins_valid_in,
   input  wire logic        high_current_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   output logic             reg_rvalid_out,
   output logic      [6:0]  overcurrent_limit_out,
   output logic      [2:0]  filter_zero_index_out,
   output logic      [3:0]  filter_zero_cap_pf_out,
   output logic      [3:0]  address_offset_out,
   output logic      [6:0]  pmbus_address_out,
   output logic      [6:0]  i2c_address_out,
   output logic      [3:0]  image_select_out,
   output logic             image_load_out,
   output logic             config_valid_out
);

   psc_strap_if strap ();

   logic [15:0] base_addr_reg;
   logic [15:0] addr_ctrl_reg;
   logic [15:0] override_reg;
   logic [15:0] ocp_value_reg;
   logic [15:0] zero_table_reg;
   logic [15:0] zero_base_reg;
   logic [2:0]  zero_code [NUM_ZERO_IDX];
   logic [6:0]  ocp_strap;
   logic [2:0]  zero_idx_strap;
   logic [2:0]  zero_code_sel;
   logic [3:0]  offset_clamped;
   logic [3:0]  offset_eff;
   logic        ocp_override;
   logic [15:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////////
   // Strap sampling stage
   psc_strap_latch #(
      .SETTLE_CYC      (SETTLE_CYC)
   ) u_latch (
      .sys_clk_in      (sys_clk_in),
      .srst_in         (srst_in),
      .ilim_bin_in     (ilim_bin_in),
      .addr_bin_in     (addr_bin_in),
      .bins_valid_in   (bins_valid_in),
      .high_current_in (high_current_in),
      .strap           (strap.latch)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, one process per register
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         base_addr_reg <= BASE_ADDR_RST;
      end else if (reg_wr_in && reg_addr_in == REG_BASE_ADDR) begin
         base_addr_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         addr_ctrl_reg <= ADDR_CTRL_RST;
      end else if (reg_wr_in && reg_addr_in == REG_ADDR_CTRL) begin
         addr_ctrl_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         override_reg <= OVERRIDE_RST;
      end else if (reg_wr_in && reg_addr_in == REG_OVERRIDE) begin
         override_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         ocp_value_reg <= OCP_VALUE_RST;
      end else if (reg_wr_in && reg_addr_in == REG_OCP_VALUE) begin
         ocp_value_reg <= reg_wdata_in;
      end
   end

   // Cap codes for filter-zero indices 1 to 4
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         zero_table_reg <= ZERO_TABLE_RST;
      end else if (reg_wr_in && reg_addr_in == REG_ZERO_TABLE) begin
         zero_table_reg <= reg_wdata_in; // RULE_05
      end
   end

   // Cap code for index 0, also the bus-written zero setting
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         zero_base_reg <= ZERO_BASE_RST;
      end else if (reg_wr_in && reg_addr_in == REG_ZERO_BASE) begin
         zero_base_reg <= reg_wdata_in; // RULE_04
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-index cap code fields: index 0 in 0x64, the rest packed in 0x62
   generate
      for (genvar i = 0; i < NUM_ZERO_IDX; i++) begin : g_zero
         if (i == 0) begin : g_base
            assign zero_code[i] =
               zero_base_reg[ZERO_BASE_LSB +: ZERO_FIELD_W]; // RULE_05
         end else begin : g_tab
            assign zero_code[i] = zero_table_reg[(i - 1) * ZERO_TABLE_STRIDE
                                  +: ZERO_FIELD_W]; // RULE_05
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Strap decode from the latched bins
   assign ocp_strap = strap.high_current ?
                      OCP_HIGH_A[strap.ilim_bin] : // RULE_01
                      OCP_LOW_A[strap.ilim_bin];   // RULE_02
   assign zero_idx_strap = ZERO_IDX_TBL[strap.ilim_bin]; // RULE_03
   assign ocp_override   = override_reg[OVR_DOCP_BIT] |
                           override_reg[OVR_AOCP_BIT]; // RULE_11
   // Override bit set means the bus value wins over the strap table
   assign zero_code_sel  = override_reg[OVR_ZERO_BIT] ?
                           zero_code[0] :               // RULE_04
                           zero_code[zero_idx_strap];   // RULE_11

   // Boards wanting larger offsets need other parts, so the clamp is safe
   assign offset_clamped = (strap.addr_bin > MAX_ADDR_OFFSET) ?
                           MAX_ADDR_OFFSET : strap.addr_bin; // RULE_08 RULE_09
   assign offset_eff     = addr_ctrl_reg[ADDR_PIN_DIS_BIT] ?
                           4'h0 : offset_clamped; // RULE_12

   ////////////////////////////////////////////////////////////////////////////
   // Current limit; zero until the straps are latched
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || !strap.latched) begin
         overcurrent_limit_out <= 7'h00;
      end else if (ocp_override) begin
         overcurrent_limit_out <= ocp_value_reg[6:0];
      end else begin
         overcurrent_limit_out <= ocp_strap; // RULE_01 RULE_02
      end
   end

   // Filter-zero index and its capacitance
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || !strap.latched) begin
         filter_zero_index_out  <= 3'h0;
         filter_zero_cap_pf_out <= 4'h0;
      end else begin
         filter_zero_index_out  <= zero_idx_strap; // RULE_03
         filter_zero_cap_pf_out <= psc_cap_pf(zero_code_sel); // RULE_03
      end
   end

   // Effective slave addresses, base plus pin offset
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         address_offset_out <= 4'h0;
         pmbus_address_out  <= 7'h00;
         i2c_address_out    <= 7'h00;
      end else begin
         address_offset_out <= offset_eff; // RULE_06
         pmbus_address_out  <= 7'(base_addr_reg[PMBUS_ADDR_LSB +: 7]
                               + {3'h0, offset_eff}); // RULE_06
         i2c_address_out    <= 7'(base_addr_reg[I2C_ADDR_LSB +: 7]
                               + {3'h0, offset_eff}); // RULE_06
      end
   end

   // Image pick: position counted from slot zero, so bin k is image k
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         image_select_out <= IMAGE_SLOT_ZERO;
         image_load_out   <= 1'b0;
         config_valid_out <= 1'b0;
      end else begin
         image_select_out <= IMAGE_SLOT_ZERO + strap.addr_bin; // RULE_07 RULE_10
         image_load_out   <= strap.load_pulse; // RULE_13
         config_valid_out <= strap.latched;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_next = 16'h0000;
      case (reg_addr_in)
         REG_BASE_ADDR:    rdata_next = base_addr_reg;
         REG_ADDR_CTRL:    rdata_next = addr_ctrl_reg;
         REG_OVERRIDE:     rdata_next = override_reg;
         REG_OCP_VALUE:    rdata_next = ocp_value_reg;
         REG_ZERO_TABLE:   rdata_next = zero_table_reg;
         REG_ZERO_BASE:    rdata_next = zero_base_reg;
         REG_STRAP_STATUS: rdata_next = {6'h00, strap.latched,
                                         strap.high_current, strap.addr_bin,
                                         strap.ilim_bin};
         default:          rdata_next = 16'h0000;
      endcase
   end

   // Read data registered, valid one cycle after the read strobe
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         reg_rdata_out  <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= rdata_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_ocp_high_map : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.latched && strap.high_current && !ocp_override
      |=> overcurrent_limit_out == OCP_HIGH_A[$past(strap.ilim_bin)]) // RULE_01
      else $error("high variant limit wrong");

   a_ocp_low_map : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.latched && !strap.high_current && !ocp_override
      |=> overcurrent_limit_out <= 7'h19) // RULE_02
      else $error("low variant limit above 25 A");

   a_zero_index : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.latched |=> filter_zero_index_out <= 3'h4 &&
      filter_zero_index_out == ZERO_IDX_TBL[$past(strap.ilim_bin)]) // RULE_03
      else $error("filter zero index wrong");

   a_zero_bus : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.latched && override_reg[OVR_ZERO_BIT] |=>
      filter_zero_cap_pf_out == psc_cap_pf($past(zero_code[0]))) // RULE_04
      else $error("bus zero setting ignored");

   a_zero_table : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) reg_wr_in && reg_addr_in == REG_ZERO_TABLE |=>
      zero_code[1] == $past(reg_wdata_in[2:0]) &&
      zero_code[4] == $past(reg_wdata_in[14:12])) // RULE_05
      else $error("zero table field misplaced");

   a_addr_offset : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) !addr_ctrl_reg[ADDR_PIN_DIS_BIT] && strap.addr_bin < 4'h5
      |=> address_offset_out == $past(strap.addr_bin)) // RULE_06
      else $error("address offset not equal to bin");

   a_image_pick : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.load_pulse |=> image_load_out &&
      image_select_out == $past(strap.addr_bin)) // RULE_07
      else $error("image select not equal to bin");

   a_offset_clamp : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) address_offset_out <= MAX_ADDR_OFFSET) // RULE_08
      else $error("address offset above 4");

   a_strap_gated : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.latched && ocp_override |=>
      overcurrent_limit_out == $past(ocp_value_reg[6:0])) // RULE_11
      else $error("override not applied to limit");

   a_pin_disable : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) addr_ctrl_reg[ADDR_PIN_DIS_BIT] |=>
      pmbus_address_out == $past(base_addr_reg[6:0])) // RULE_12
      else $error("pin offset not dropped");

endmodule : psc_config_decoder
`default_nettype wire

/* File: design/psc_pkg.sv */
// Shared constants, tables and types for the pin-strap configuration decoder
package psc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (command codes)
   localparam logic [7:0] REG_BASE_ADDR    = 8'h40;
   localparam logic [7:0] REG_ADDR_CTRL    = 8'h42;
   localparam logic [7:0] REG_OVERRIDE     = 8'h5E;
   localparam logic [7:0] REG_OCP_VALUE    = 8'h5F;
   localparam logic [7:0] REG_STRAP_STATUS = 8'h60;
   localparam logic [7:0] REG_ZERO_TABLE   = 8'h62;
   localparam logic [7:0] REG_ZERO_BASE    = 8'h64;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PMBUS_ADDR_LSB    = 0;
   localparam int I2C_ADDR_LSB      = 8;
   localparam int ADDR_PIN_DIS_BIT  = 6;
   localparam int OVR_DOCP_BIT      = 0;
   localparam int OVR_AOCP_BIT      = 1;
   localparam int OVR_ZERO_BIT      = 2;
   localparam int ZERO_BASE_LSB     = 12;
   localparam int ZERO_TABLE_STRIDE = 4;
   localparam int ZERO_FIELD_W      = 3;
   localparam int NUM_ZERO_IDX      = 5;
   localparam int NUM_BINS          = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] BASE_ADDR_RST = 16'h1010;
   localparam logic [15:0] ADDR_CTRL_RST = 16'h0000;
   localparam logic [15:0] OVERRIDE_RST  = 16'h0000;
   localparam logic [15:0] OCP_VALUE_RST = 16'h001E;
   localparam logic [15:0] ZERO_TABLE_RST = 16'h4321;
   localparam logic [15:0] ZERO_BASE_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Limits and timing
   localparam logic [3:0] MAX_ADDR_OFFSET = 4'h4;
   localparam logic [3:0] IMAGE_SLOT_ZERO = 4'h0;
   localparam int CLK_PERIOD_NS    = 50;
   localparam int STRAP_SETTLE_NS  = 10000;
   localparam int STRAP_SETTLE_CYC =
      (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Bin tables, bin 0 = shorted pin, bin 15 = floating pin
   localparam logic [6:0] OCP_HIGH_A [NUM_BINS] = '{
      7'h0F, 7'h3C, 7'h14, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E,
      7'h28, 7'h32, 7'h19, 7'h3C, 7'h28, 7'h32, 7'h0A, 7'h1E};
   localparam logic [6:0] OCP_LOW_A [NUM_BINS] = '{
      7'h0F, 7'h0F, 7'h14, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h0A,
      7'h0F, 7'h14, 7'h19, 7'h0A, 7'h0F, 7'h14, 7'h0A, 7'h19};
   localparam logic [2:0] ZERO_IDX_TBL [NUM_BINS] = '{
      3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
      3'h3, 3'h4, 3'h1, 3'h3, 3'h2, 3'h3, 3'h1, 3'h3};
   localparam logic [3:0] ZERO_CAP_PF [NUM_ZERO_IDX] = '{
      4'h1, 4'h2, 4'h4, 4'h6, 4'h8};

   ////////////////////////////////////////////////////////////////////////////
   // Capacitor code to picofarads; codes past the last saturate
   function automatic logic [3:0] psc_cap_pf(input logic [2:0] code);
      logic [3:0] pf;
      pf = ZERO_CAP_PF[NUM_ZERO_IDX-1];
      if (code < 3'(NUM_ZERO_IDX)) begin
         pf = ZERO_CAP_PF[code];
      end
      return pf;
   endfunction : psc_cap_pf

   typedef enum logic [1:0] {
      ST_SETTLE    = 2'b00,
      ST_WAIT_BINS = 2'b01,
      ST_LOAD      = 2'b11,
      ST_DONE      = 2'b10
   } psc_state_e;

endpackage : psc_pkg

/* File: design/psc_strap_if.sv */
// Latched strap results passed from the latch stage to the decoder
`timescale 1ns/1ps
`default_nettype none
interface psc_strap_if;
   logic [3:0] ilim_bin;
   logic [3:0] addr_bin;
   logic       high_current;
   logic       latched;
   logic       load_pulse;

   modport latch (output ilim_bin, addr_bin, high_current, latched,
                  load_pulse);
   modport use_side (input ilim_bin, addr_bin, high_current, latched,
                     load_pulse);
endinterface : psc_strap_if
`default_nettype wire

/* File: design/psc_strap_latch.sv */
// One-shot sampler of the strap bins after power-on reset
`timescale 1ns/1ps
`default_nettype none
module psc_strap_latch
   import psc_pkg::*;
#(
   parameter int SETTLE_CYC = STRAP_SETTLE_CYC
)(
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic [3:0] ilim_bin_in,
   input  wire logic [3:0] addr_bin_in,
   input  wire logic       bins_valid_in,
   input  wire logic       high_current_in,
   psc_strap_if.latch      strap
);

   psc_state_e  state_reg;
   logic [15:0] settle_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: settle, sample once, request image load, then hold
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_reg <= ST_SETTLE;
      end else begin
         case (state_reg)
            ST_SETTLE: begin
               if (settle_reg == 16'(SETTLE_CYC - 1)) begin
                  state_reg <= ST_WAIT_BINS;
               end
            end
            ST_WAIT_BINS: begin
               if (bins_valid_in) begin
                  state_reg <= ST_LOAD; // RULE_13
               end
            end
            ST_LOAD: state_reg <= ST_DONE;
            ST_DONE: state_reg <= ST_DONE; // Held until next power-up
            default: state_reg <= ST_SETTLE;
         endcase
      end
   end

   // Settle counter lets the measured bins stabilise before sampling
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         settle_reg <= 16'h0000;
      end else if (state_reg == ST_SETTLE) begin
         settle_reg <= settle_reg + 16'h0001;
      end
   end

   // Capture bins and variant strap exactly once, after reset release
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         strap.ilim_bin     <= 4'h0;
         strap.addr_bin     <= 4'h0;
         strap.high_current <= 1'b0;
      end else if (state_reg == ST_WAIT_BINS && bins_valid_in) begin
         strap.ilim_bin     <= ilim_bin_in; // RULE_13
         strap.addr_bin     <= addr_bin_in; // RULE_13
         strap.high_current <= high_current_in;
      end
   end

   // Load request is one cycle, ahead of any later use of the values
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         strap.latched    <= 1'b0;
         strap.load_pulse <= 1'b0;
      end else begin
         strap.load_pulse <= (state_reg == ST_WAIT_BINS) && bins_valid_in;
         if (state_reg == ST_WAIT_BINS && bins_valid_in) begin
            strap.latched <= 1'b1; // RULE_13
         end
      end
   end

   a_sample_once : assert property (@(posedge sys_clk_in) disable iff
      (srst_in) strap.latched |=> $stable(strap.ilim_bin) &&
      $stable(strap.addr_bin)) // RULE_13
      else $error("strap bins changed after latch");

endmodule : psc_strap_latch
`default_nettype wire

/* File: sim/psc_strap_model.sv */
// Strap resistor model for the limit pin and the shared pin
`timescale 1ns/1ps
`default_nettype none
module psc_strap_model (
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic [3:0] ilim_sel_in,
   input  wire logic [3:0] addr_sel_in,
   input  wire logic       hc_sel_in,
   input  wire logic       slow_in,
   output logic      [3:0] ilim_bin_out,
   output logic      [3:0] addr_bin_out,
   output logic            bins_valid_out,
   output logic            high_current_out
);
   logic [5:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Measurement time since reset release, saturating
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cnt_reg <= 6'h00;
      end else if (cnt_reg != 6'h3F) begin
         cnt_reg <= cnt_reg + 6'h01;
      end
   end

   // Short or long settle; bins wander until measured, never stale
   assign bins_valid_out   = !srst_in && (cnt_reg > (slow_in ? 6'h1E : 6'h01));
   assign ilim_bin_out     = bins_valid_out ? ilim_sel_in : ~cnt_reg[3:0];
   // Bins above 4 probe the offset clamp and also pick images 5 to 15
   assign addr_bin_out     = bins_valid_out ? addr_sel_in : cnt_reg[3:0];
   assign high_current_out = hc_sel_in;
endmodule : psc_strap_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the pin-strap configuration decoder
`timescale 1ns/1ps
`default_nettype none
module tb import psc_pkg::*;;
   logic        sys_clk, srst, hc_sel, slow, reg_wr, reg_rd;
   logic [3:0]  ilim_sel, addr_sel, ilim_bin, addr_bin, zcap, off, img;
   logic        bins_valid, high_cur, rvalid, img_load, cfg_valid;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, rdata;
   logic [6:0]  lim, pm_addr, i2c_addr;
   logic [2:0]  zidx;
   int          mismatches, n_tests;
   // Expected limits, zero indices and caps per bin
   localparam logic [6:0] HI_A [16] = '{7'h0F, 7'h3C, 7'h14, 7'h0A, 7'h0F,
      7'h14, 7'h19, 7'h1E, 7'h28, 7'h32, 7'h19, 7'h3C, 7'h28, 7'h32, 7'h0A,
      7'h1E};
   localparam logic [6:0] LO_A [16] = '{7'h0F, 7'h0F, 7'h14, 7'h0A, 7'h0F,
      7'h14, 7'h19, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h0A, 7'h0F, 7'h14, 7'h0A,
      7'h19};
   localparam logic [2:0] ZI [16] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h1,
      3'h2, 3'h2, 3'h3, 3'h4, 3'h1, 3'h3, 3'h2, 3'h3, 3'h1, 3'h3};
   localparam logic [3:0] CAP [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};

   ////////////////////////////////////////////////////////////////////////////
   // Short settle keeps each power-up brief
   psc_config_decoder #(.SETTLE_CYC(4)) u_psc_config_decoder (
      .sys_clk_in(sys_clk), .srst_in(srst), .ilim_bin_in(ilim_bin),
      .addr_bin_in(addr_bin), .bins_valid_in(bins_valid),
      .high_current_in(high_cur), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .overcurrent_limit_out(lim), .filter_zero_index_out(zidx),
      .filter_zero_cap_pf_out(zcap), .address_offset_out(off),
      .pmbus_address_out(pm_addr), .i2c_address_out(i2c_addr),
      .image_select_out(img), .image_load_out(img_load),
      .config_valid_out(cfg_valid));
   psc_strap_model u_psc_strap_model (
      .sys_clk_in(sys_clk), .srst_in(srst), .ilim_sel_in(ilim_sel),
      .addr_sel_in(addr_sel), .hc_sel_in(hc_sel), .slow_in(slow),
      .ilim_bin_out(ilim_bin), .addr_bin_out(addr_bin),
      .bins_valid_out(bins_valid), .high_current_out(high_cur));

   // 20 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Write strobe for one edge, then let the effect reach the outputs
   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask : reg_write

   // Data and valid stand one cycle after the read edge
   task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      check("rvalid", 16'(rvalid), 16'h0001);
      check("rdata", rdata, exp);
      // Valid is a one-cycle pulse, data holds
      @(negedge sys_clk);
      check("rvalid end", 16'(rvalid), 16'h0000);
      check("rdata hold", rdata, exp);
   endtask : reg_read

   // Reset with given straps, wait bounded for config valid, then check the one load pulse
   task automatic power_up(input logic [3:0] il, input logic [3:0] ad,
                           input logic hc, input logic sl);
      @(posedge sys_clk);
      ilim_sel <= il;
      addr_sel <= ad;
      hc_sel <= hc;
      slow <= sl;
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 80; i++) begin
         @(negedge sys_clk);
         if (cfg_valid === 1'b1) break;
      end
      if (cfg_valid !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
      check("load pulse", 16'(img_load), 16'h0001);
      @(negedge sys_clk);
      check("load end", 16'(img_load), 16'h0000);
   endtask : power_up

   ////////////////////////////////////////////////////////////////////////////
   // Every bin on one variant; slow settle on odd bins
   task automatic sc_bins(input logic hc);
      logic [3:0] o;
      for (int k = 0; k < 16; k++) begin
         o = (k > 4) ? 4'h4 : 4'(k);
         power_up(4'(k), 4'(k), hc, k[0]);
         check("limit", 16'(lim), 16'(hc ? HI_A[k] : LO_A[k]));
         check("zidx", 16'(zidx), 16'(ZI[k]));
         check("zcap", 16'(zcap), 16'(CAP[ZI[k]]));
         check("image", 16'(img), 16'(k));
         check("offset", 16'(off), 16'(o));
         check("pmbus", 16'(pm_addr), 16'(7'h10 + 7'(o)));
         check("i2c", 16'(i2c_addr), 16'(7'h10 + 7'(o)));
      end
   endtask : sc_bins

   // Reset values, an unmapped offset, the cap table and both overrides
   task automatic sc_override();
      power_up(4'h8, 4'h2, 1'b1, 1'b0);
      reg_read(REG_ZERO_TABLE, 16'h4321);
      reg_read(REG_OVERRIDE, 16'h0000);
      reg_write(8'h70, 16'hFFFF);
      reg_read(8'h70, 16'h0000);
      reg_write(REG_ZERO_TABLE, 16'h4121);
      check("zcap", 16'(zcap), 16'h0002);
      reg_write(REG_ZERO_BASE, 16'h4000);
      reg_read(REG_ZERO_BASE, 16'h4000);
      check("zcap", 16'(zcap), 16'h0002);
      reg_write(REG_OVERRIDE, 16'h0004);
      check("zcap", 16'(zcap), 16'h0008);
      check("zidx", 16'(zidx), 16'h0003);
      reg_write(REG_OCP_VALUE, 16'h002D);
      check("limit", 16'(lim), 16'h0028);
      reg_write(REG_OVERRIDE, 16'h0002);
      check("limit", 16'(lim), 16'h002D);
      reg_write(REG_OVERRIDE, 16'h0001);
      check("limit", 16'(lim), 16'h002D);
      check("zcap", 16'(zcap), 16'h0002);
   endtask : sc_override

   // Pin offset dropped, image choice kept
   task automatic sc_addr_off();
      power_up(4'h0, 4'h9, 1'b1, 1'b1);
      reg_read(REG_ADDR_CTRL, 16'h0000);
      reg_write(REG_ADDR_CTRL, 16'h0040);
      check("offset", 16'(off), 16'h0000);
      check("pmbus", 16'(pm_addr), 16'h0010);
      check("i2c", 16'(i2c_addr), 16'h0010);
      check("image", 16'(img), 16'h0009);
      // Distinct base fields, so a swapped field select shows up
      reg_write(REG_BASE_ADDR, 16'h1420);
      check("pmbus", 16'(pm_addr), 16'h0020);
      check("i2c", 16'(i2c_addr), 16'h0014);
   endtask : sc_addr_off

   // Straps moving after the latch must not disturb anything
   task automatic sc_hold();
      power_up(4'h1, 4'h3, 1'b1, 1'b0);
      @(posedge sys_clk);
      ilim_sel <= 4'h5;
      addr_sel <= 4'h7;
      hc_sel <= 1'b0;
      repeat (6) @(negedge sys_clk);
      check("limit", 16'(lim), 16'h003C);
      check("image", 16'(img), 16'h0003);
      check("valid", 16'(cfg_valid), 16'h0001);
      check("load", 16'(img_load), 16'h0000);
      reg_write(REG_STRAP_STATUS, 16'hFFFF);
      reg_read(REG_STRAP_STATUS, 16'h0331);
   endtask : sc_hold

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {srst, hc_sel, slow, reg_wr, reg_rd} = 5'h10;
      {ilim_sel, addr_sel, reg_addr, reg_wdata} = 32'h0000_0000;
      mismatches = 0;
      n_tests = 0;
      sc_bins(1'b1);
      sc_bins(1'b0);
      sc_override();
      sc_addr_off();
      sc_hold();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
